// ---- rtl/light_sensor_readout_and_alert.sv ----
/*
  Register side of a two-channel integrating light sensor: serial slave, result
  shadowing, integration timing and channel-0 threshold interrupt.
  Assumes scl_in/sda_in already synchronous to clk; the analog front end integrates
  while integrate is high and presents its counts on sample at all times.
*/
`timescale 1ns/1ps
module light_sensor_readout_and_alert #(
  parameter logic [6:0] SLAVE_ADDR = light_sensor_pkg::DEFAULT_SLAVE_ADDR,
  parameter logic [3:0] PART_CODE = 4'h5,      // Arbitrary value
  parameter logic [3:0] REVISION_CODE = 4'h3,  // Arbitrary value
  parameter int COUNT_WIDTH = 27,
  parameter int CYCLES_SHORT = light_sensor_pkg::CYCLES_SHORT,
  parameter int CYCLES_MEDIUM = light_sensor_pkg::CYCLES_MEDIUM,
  parameter int CYCLES_LONG = light_sensor_pkg::CYCLES_LONG
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Analog front end
  input wire light_sensor_pkg::sample_type sample,
  output logic analog_power,
  output logic high_gain,
  output logic integrate,
  // Interrupt line
  output logic interrupt_n
);
  import light_sensor_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bus_state_type state, next_state;
  logic scl_prev, sda_prev;
  logic [3:0] bit_count, next_bit_count;
  logic [7:0] shift, next_shift;
  logic [7:0] tx, next_tx;
  logic [3:0] pointer, next_pointer;
  logic word_mode, next_word_mode;
  logic read_dir, next_read_dir;
  logic alert_cycle, next_alert_cycle;
  logic first_byte, next_first_byte;
  logic next_sda_oe;
  logic wr_strobe, cmd_strobe, rd_strobe, alert_done, load_byte;

  logic [1:0] control, next_control;
  logic [1:0] integ_code, next_integ_code;
  logic manual_bit, next_manual_bit, next_high_gain;
  logic [15:0] thresh_low, next_thresh_low, thresh_high, next_thresh_high;
  logic [1:0] style, next_style;
  logic [3:0] persist, next_persist, persist_count, next_persist_count;
  sample_type result, next_result;
  logic [7:0] shadow0, next_shadow0, shadow1, next_shadow1;
  logic [COUNT_WIDTH-1:0] count, next_count;
  logic manual_run, next_manual_run;
  logic next_analog_power, next_integrate, next_interrupt_n;
  logic conv_done, fire, test_set, clear_event;

  logic scl_rise, scl_fall, start_seen, stop_seen, alert_pending;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_value(input logic [3:0] addr);
    case (addr)
      ADDR_CONTROL: read_value = {6'h00, control};
      ADDR_TIMING: read_value = {3'h0, high_gain, manual_bit, 1'b0, integ_code};
      ADDR_THRESH_LOW_LO: read_value = thresh_low[7:0];
      ADDR_THRESH_LOW_HI: read_value = thresh_low[15:8];
      ADDR_THRESH_HIGH_LO: read_value = thresh_high[7:0];
      ADDR_THRESH_HIGH_HI: read_value = thresh_high[15:8];
      ADDR_INTERRUPT: read_value = {2'h0, style, persist};
      ADDR_PART_IDENTITY: read_value = {PART_CODE, REVISION_CODE};
      ADDR_CHANNEL0_LOW: read_value = result.broadband[7:0];
      ADDR_CHANNEL0_HIGH: read_value = shadow0;
      ADDR_CHANNEL1_LOW: read_value = result.infrared[7:0];
      ADDR_CHANNEL1_HIGH: read_value = shadow1;
      default: read_value = 8'h00;
    endcase
  endfunction

  function automatic logic [COUNT_WIDTH-1:0] period_cycles(input logic [1:0] code);
    case (code)
      INTEG_SHORT: period_cycles = COUNT_WIDTH'(CYCLES_SHORT);
      INTEG_MEDIUM: period_cycles = COUNT_WIDTH'(CYCLES_MEDIUM);
      default: period_cycles = COUNT_WIDTH'(CYCLES_LONG);
    endcase
  endfunction

  assign scl_rise = ~scl_prev & scl_in;
  assign scl_fall = scl_prev & ~scl_in;
  assign start_seen = scl_prev & scl_in & sda_prev & ~sda_in;
  assign stop_seen = scl_prev & scl_in & ~sda_prev & sda_in;
  assign alert_pending = ~interrupt_n & style[1];

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_bit_count = bit_count;
    next_shift = shift;
    next_tx = tx;
    next_pointer = pointer;
    next_word_mode = word_mode;
    next_read_dir = read_dir;
    next_alert_cycle = alert_cycle;
    next_first_byte = first_byte;
    next_sda_oe = sda_oe;
    wr_strobe = 1'b0;
    cmd_strobe = 1'b0;
    rd_strobe = 1'b0;
    alert_done = 1'b0;
    load_byte = 1'b0;
    if (stop_seen) begin
      next_state = BUS_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_seen) begin
      next_state = BUS_ADDR;
      next_bit_count = 4'h0;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        BUS_ADDR: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_in};
            next_bit_count = bit_count + 4'h1;
          end else if (scl_fall && bit_count == 4'h8) begin
            if (shift[7:1] == SLAVE_ADDR ||
                (shift[7:1] == ALERT_RESPONSE_ADDR && shift[0] && alert_pending)) begin
              next_sda_oe = 1'b1;
              next_state = BUS_ADDR_ACK;
              next_read_dir = shift[0];
              next_alert_cycle = (shift[7:1] == ALERT_RESPONSE_ADDR);
            end else begin
              next_state = BUS_IDLE;
            end
          end
        end
        BUS_ADDR_ACK: begin
          if (scl_fall) begin
            next_bit_count = 4'h0;
            next_first_byte = 1'b1;
            if (read_dir) begin
              load_byte = 1'b1;
            end else begin
              next_sda_oe = 1'b0;
              next_state = BUS_WRITE;
            end
          end
        end
        BUS_WRITE: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_in};
            next_bit_count = bit_count + 4'h1;
          end else if (scl_fall && bit_count == 4'h8) begin
            next_sda_oe = 1'b1;
            next_state = BUS_WRITE_ACK;
            if (first_byte) begin
              if (shift[CMD_MARK_BIT]) begin
                cmd_strobe = 1'b1;
                next_pointer = shift[3:0];
                next_word_mode = shift[CMD_WORD_BIT];
              end
            end else begin
              wr_strobe = 1'b1;
              if (word_mode) begin
                next_pointer = pointer + 4'h1;
              end
            end
          end
        end
        BUS_WRITE_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_bit_count = 4'h0;
            next_first_byte = 1'b0;
            next_state = BUS_WRITE;
          end
        end
        BUS_READ: begin
          if (scl_rise) begin
            next_bit_count = bit_count + 4'h1;
            // Lost arbitration on the alert answer: back off, interrupt kept
            if (alert_cycle && tx[7] && !sda_in) begin
              next_state = BUS_IDLE;
              next_sda_oe = 1'b0;
            end
          end else if (scl_fall) begin
            if (bit_count == 4'h8) begin
              next_sda_oe = 1'b0;
              next_state = BUS_READ_ACK;
              alert_done = alert_cycle;
            end else begin
              next_tx = {tx[6:0], 1'b0};
              next_sda_oe = ~tx[6];
            end
          end
        end
        BUS_READ_ACK: begin
          if (scl_rise && sda_in) begin
            next_state = BUS_IDLE;
          end else if (scl_fall) begin
            next_bit_count = 4'h0;
            load_byte = 1'b1;
          end
        end
        default: next_state = BUS_IDLE;
      endcase
      if (load_byte) begin
        next_state = BUS_READ;
        if (alert_cycle) begin
          next_tx = {SLAVE_ADDR, 1'b0};
        end else begin
          next_tx = read_value(pointer);
          rd_strobe = 1'b1;
          if (word_mode) begin
            next_pointer = pointer + 4'h1;
          end
        end
        next_sda_oe = ~next_tx[7];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= BUS_IDLE;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      bit_count <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      pointer <= 4'h0;
      word_mode <= 1'b0;
      read_dir <= 1'b0;
      alert_cycle <= 1'b0;
      first_byte <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      state <= next_state;
      scl_prev <= scl_in;
      sda_prev <= sda_in;
      bit_count <= next_bit_count;
      shift <= next_shift;
      tx <= next_tx;
      pointer <= next_pointer;
      word_mode <= next_word_mode;
      read_dir <= next_read_dir;
      alert_cycle <= next_alert_cycle;
      first_byte <= next_first_byte;
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers, conversion timing and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    next_control = control;
    next_integ_code = integ_code;
    next_manual_bit = manual_bit;
    next_high_gain = high_gain;
    next_thresh_low = thresh_low;
    next_thresh_high = thresh_high;
    next_style = style;
    next_persist = persist;
    next_result = result;
    next_shadow0 = shadow0;
    next_shadow1 = shadow1;
    next_count = count;
    next_manual_run = manual_run;
    next_persist_count = persist_count;
    next_interrupt_n = interrupt_n;
    conv_done = 1'b0;
    fire = 1'b0;
    test_set = 1'b0;
    // Result bytes and identity have no write path
    if (wr_strobe) begin
      case (pointer)
        ADDR_CONTROL: next_control = shift[1:0];
        ADDR_TIMING: begin
          next_high_gain = shift[TIMING_GAIN_BIT];
          next_manual_bit = shift[TIMING_MANUAL_BIT];
          next_integ_code = shift[1:0];
        end
        ADDR_THRESH_LOW_LO: next_thresh_low[7:0] = shift;
        ADDR_THRESH_LOW_HI: next_thresh_low[15:8] = shift;
        ADDR_THRESH_HIGH_LO: next_thresh_high[7:0] = shift;
        ADDR_THRESH_HIGH_HI: next_thresh_high[15:8] = shift;
        ADDR_INTERRUPT: begin
          next_style = shift[INTERRUPT_STYLE_SELECT_STYLE_LSB +: 2];
          next_persist = shift[INTERRUPT_STYLE_SELECT_PERSIST_LSB +: 4];
          test_set = (shift[INTERRUPT_STYLE_SELECT_STYLE_LSB +: 2] == STYLE_TEST);
        end
        default: ;
      endcase
    end
    // Shadow taken from the same result word that feeds the low byte
    if (rd_strobe && pointer == ADDR_CHANNEL0_LOW) begin
      next_shadow0 = result.broadband[15:8];
    end
    if (rd_strobe && pointer == ADDR_CHANNEL1_LOW) begin
      next_shadow1 = result.infrared[15:8];
    end
    if (control != POWER_UP_CODE) begin
      next_count = '0;
      next_manual_run = 1'b0;
    end else if (integ_code != INTEG_MANUAL) begin
      next_manual_run = 1'b0;
      if (count >= period_cycles(integ_code) - COUNT_WIDTH'(1)) begin
        next_count = '0;
        conv_done = 1'b1;
      end else begin
        next_count = count + COUNT_WIDTH'(1);
      end
    end else begin
      next_count = '0;
      next_manual_run = manual_bit;
      conv_done = manual_run & ~manual_bit;
    end
    if (conv_done) begin
      next_result = sample;
      if (persist == 4'h0) begin
        fire = 1'b1;
      end else if (sample.broadband <= thresh_low || sample.broadband > thresh_high) begin
        if (persist_count + 4'h1 >= persist) begin
          fire = 1'b1;
          next_persist_count = 4'h0;
        end else begin
          next_persist_count = persist_count + 4'h1;
        end
      end else begin
        next_persist_count = 4'h0;
      end
    end
    clear_event = (cmd_strobe && shift[CMD_CLEAR_BIT] && style == STYLE_LEVEL) ||
                  (alert_done && style[1]);
    if (clear_event) begin
      next_interrupt_n = 1'b1;
    end
    // Set wins over a clear arriving in the same cycle
    if (fire || test_set) begin
      next_interrupt_n = 1'b0;
    end
    if (next_style == STYLE_OFF) begin
      next_interrupt_n = 1'b1;
    end
    next_analog_power = (next_control == POWER_UP_CODE);
    next_integrate = next_analog_power &&
                     (next_integ_code != INTEG_MANUAL || next_manual_bit);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control <= CONTROL_RESET;
      integ_code <= INTEG_RESET;
      manual_bit <= 1'b0;
      high_gain <= 1'b0;
      thresh_low <= 16'h0000;
      thresh_high <= 16'h0000;
      style <= STYLE_OFF;
      persist <= 4'h0;
      result <= '0;
      shadow0 <= BYTE_RESET;
      shadow1 <= BYTE_RESET;
      count <= '0;
      manual_run <= 1'b0;
      persist_count <= 4'h0;
      interrupt_n <= 1'b1;
      analog_power <= 1'b0;
      integrate <= 1'b0;
    end else begin
      control <= next_control;
      integ_code <= next_integ_code;
      manual_bit <= next_manual_bit;
      high_gain <= next_high_gain;
      thresh_low <= next_thresh_low;
      thresh_high <= next_thresh_high;
      style <= next_style;
      persist <= next_persist;
      result <= next_result;
      shadow0 <= next_shadow0;
      shadow1 <= next_shadow1;
      count <= next_count;
      manual_run <= next_manual_run;
      persist_count <= next_persist_count;
      interrupt_n <= next_interrupt_n;
      analog_power <= next_analog_power;
      integrate <= next_integrate;
    end
  end

endmodule // light_sensor_readout_and_alert

// ---- rtl/light_sensor_pkg.sv ----
/*
  Shared constants and types for the two-channel light sensor register block.
  Assumes a single device clock and a host reaching the block over a two-wire serial link.
*/
// Contract
// - Identity byte is constant read-only; part code upper nibble, revision lower.
// - Each channel is 16 bits over a byte pair; channel 0 at C/D, 1 at E/F.
// - Result bytes ignore host writes and hold zero after power-up.
// - Reading a low result byte latches its high byte into a shadow.
// - Shadowed high byte stays paired with the low byte despite new conversions.
// - Word read at a low result byte returns low then next byte.
// - Command byte: bit 7 marker, bit 5 word select, low nibble register address.
// - Device starts powered down; writing 3 to control powers up and converts.
// - Default integration is about 400 ms; results readable after it ends.
// - Integration code 0 is 13.7 ms, 1 is 101 ms, 2 is 402 ms default.
// - Timing bit 4 selects 16x gain independent of integration code.
// - Code 3 is manual; bit 3 set starts, clear ends and latches results.
// - Interrupt style zero disables the interrupt output entirely.
// - Only channel 0 is compared against a low and a high threshold.
// - Persistence 1 fires on one out-of-range result; N needs N consecutive.
// - Persistence 0 fires at every conversion end, thresholds ignored.
// - Interrupt line is driven low and held until cleared.
// - Level style clears on a command byte with bit 6 set.
// - Alert style clears only on completing an alert response read.
// - Style field: 0 off, 1 level, 2 alert, 3 test asserts then alert.
// - Answer alert response with own address; keep interrupt if arbitration lost.
// - Out of window means at or below low threshold, or above high.
package light_sensor_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TIMING = 4'h1;
  localparam logic [3:0] ADDR_THRESH_LOW_LO = 4'h2;
  localparam logic [3:0] ADDR_THRESH_LOW_HI = 4'h3;
  localparam logic [3:0] ADDR_THRESH_HIGH_LO = 4'h4;
  localparam logic [3:0] ADDR_THRESH_HIGH_HI = 4'h5;
  localparam logic [3:0] ADDR_INTERRUPT = 4'h6;
  localparam logic [3:0] ADDR_PART_IDENTITY = 4'hA;
  localparam logic [3:0] ADDR_CHANNEL0_LOW = 4'hC;
  localparam logic [3:0] ADDR_CHANNEL0_HIGH = 4'hD;
  localparam logic [3:0] ADDR_CHANNEL1_LOW = 4'hE;
  localparam logic [3:0] ADDR_CHANNEL1_HIGH = 4'hF;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int CMD_MARK_BIT = 7;
  localparam int CMD_CLEAR_BIT = 6;
  localparam int CMD_WORD_BIT = 5;
  localparam int TIMING_GAIN_BIT = 4;
  localparam int TIMING_MANUAL_BIT = 3;
  localparam int INTERRUPT_STYLE_SELECT_STYLE_LSB = 4;
  localparam int INTERRUPT_STYLE_SELECT_PERSIST_LSB = 0;
  localparam logic [1:0] POWER_UP_CODE = 2'h3;
  localparam logic [1:0] INTEG_SHORT = 2'h0;
  localparam logic [1:0] INTEG_MEDIUM = 2'h1;
  localparam logic [1:0] INTEG_LONG = 2'h2;
  localparam logic [1:0] INTEG_MANUAL = 2'h3;
  localparam logic [1:0] STYLE_OFF = 2'h0;
  localparam logic [1:0] STYLE_LEVEL = 2'h1;
  localparam logic [1:0] STYLE_ALERT = 2'h2;
  localparam logic [1:0] STYLE_TEST = 2'h3;
  localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;
  localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h39;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [1:0] INTEG_RESET = INTEG_LONG;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TIME_SHORT_US = 13700;
  localparam int TIME_MEDIUM_US = 101000;
  localparam int TIME_LONG_US = 402000;
  localparam int CYCLES_SHORT = TIME_SHORT_US * CLK_MHZ;
  localparam int CYCLES_MEDIUM = TIME_MEDIUM_US * CLK_MHZ;
  localparam int CYCLES_LONG = TIME_LONG_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] broadband;
    logic [15:0] infrared;
  } sample_type;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_ADDR_ACK = 3'b010,
    BUS_WRITE = 3'b011,
    BUS_WRITE_ACK = 3'b100,
    BUS_READ = 3'b101,
    BUS_READ_ACK = 3'b110
  } bus_state_type;

endpackage

// ---- verification/light_sensor_readout_and_alert_monitor.sv ----
/*
  Port checker for the light sensor register block, bound to its top module.
  Assumes scl_in is already synchronous to clk and reset_n is active low.
*/
`timescale 1ns/1ps
module light_sensor_readout_and_alert_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial link
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Front end and interrupt
  input wire light_sensor_pkg::sample_type sample,
  input wire logic analog_power,
  input wire logic high_gain,
  input wire logic integrate,
  input wire logic interrupt_n
);
  import light_sensor_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_power_gates_integrate: assert property (integrate |-> analog_power) else $error("integrate unpowered");
  a_power_starts_conv: assert property ($rose(analog_power) |-> integrate) else $error("no start");
  a_power_on_fall: assert property ($changed(analog_power) |-> !scl_in) else $error("power off-fall");
  a_gain_on_fall: assert property ($changed(high_gain) |-> !scl_in) else $error("gain off-fall");
  a_sda_quiet_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe)) else $error("sda moved");
  a_ack_holds: assert property ($rose(sda_oe) |-> sda_oe [*3]) else $error("ack too short");
  a_open_drain_low: assert property (sda_oe |-> !sda_out && !sda_in) else $error("sda not low");
  a_release_at_fall: assert property ($rose(interrupt_n) |-> !scl_in && ($past(scl_in, 1) || $past(scl_in, 2)
    || $past(scl_in, 3))) else $error("release off-fall");
  a_fire_needs_power: assert property ($fell(interrupt_n) |-> analog_power) else $error("fire unpowered");
  c_fire: cover property ($fell(interrupt_n));
  c_ack: cover property ($rose(sda_oe));
  c_manual_stop: cover property ($fell(integrate));
endmodule // light_sensor_readout_and_alert_monitor

bind light_sensor_readout_and_alert light_sensor_readout_and_alert_monitor u_light_sensor_readout_and_alert_monitor (
  .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .sample(sample), .analog_power(analog_power), .high_gain(high_gain), .integrate(integrate),
  .interrupt_n(interrupt_n));

// ---- verification/light_sensor_host_model.sv ----
/*
  Two-wire host master model: start, stop and byte transfer tasks.
  Assumes the bench resolves SDA as open drain with a pull-up.
*/
`timescale 1ns/1ps
module light_sensor_host_model (
  // Clock
  input wire logic clk,
  // Wire
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Four clocks per phase keeps data setup well above two clocks
  task automatic hold(input logic c, input logic p);
    @(posedge clk);
    scl <= c;
    sda_pull <= p;
    repeat (3) @(posedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    hold(1'b0, sda_pull);
    hold(1'b0, !b);
    hold(1'b1, !b);
    r = sda;
  endtask
  task automatic start();
    hold(1'b0, sda_pull);
    hold(1'b0, 1'b0);
    hold(1'b1, 1'b0);
    hold(1'b1, 1'b1);
  endtask
  task automatic stop();
    hold(1'b0, sda_pull);
    hold(1'b0, 1'b1);
    hold(1'b1, 1'b1);
    hold(1'b1, 1'b0);
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, ack);
  endtask
endmodule // light_sensor_host_model

// ---- verification/light_sensor_readout_and_alert_tb.sv ----
/*
  Self-checking bench for the light sensor register block, driven through the host model.
  Assumes a pull-up on SDA, resolved here from both parties' pull-downs.
*/
`timescale 1ns/1ps
module light_sensor_readout_and_alert_tb;
  import light_sensor_pkg::*;
  localparam int PERIOD = 3000;
  localparam logic [7:0] DEV_W = {DEFAULT_SLAVE_ADDR, 1'b0};
  logic clk, reset_n, scl, pull, sda, sda_out, sda_oe, analog_power, high_gain, integrate, interrupt_n, ack;
  sample_type sample;
  logic [7:0] q;
  logic [15:0] v;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  assign sda = !(sda_oe || pull);
  light_sensor_host_model u_light_sensor_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
  // Identity codes 6 and 2 are arbitrary
  light_sensor_readout_and_alert #(.PART_CODE(4'h6), .REVISION_CODE(4'h2), .CYCLES_SHORT(1000),
    .CYCLES_MEDIUM(2000), .CYCLES_LONG(PERIOD)) u_light_sensor_readout_and_alert (.clk(clk),
    .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .sample(sample),
    .analog_power(analog_power), .high_gain(high_gain), .integrate(integrate), .interrupt_n(interrupt_n));

  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] b);
    u_light_sensor_host_model.xfer(b, 1'b1, q, ack);
    chk(16'(ack), 16'h0000);
  endtask
  task automatic wreg(input logic [7:0] cmd, input int n, input logic [15:0] d);
    u_light_sensor_host_model.start();
    put(DEV_W);
    put(cmd);
    for (int i = 0; i < n; i++) put(d[8*i+:8]);
    u_light_sensor_host_model.stop();
  endtask
  task automatic rd(input logic [7:0] cmd, input int n, input logic [15:0] exp);
    v = 16'h0000;
    u_light_sensor_host_model.start();
    put(DEV_W);
    put(cmd);
    u_light_sensor_host_model.start();
    put(DEV_W | 8'h01);
    for (int i = 0; i < n; i++) begin
      u_light_sensor_host_model.xfer(8'hFF, i == n - 1, q, ack);
      v[8*i+:8] = q;
    end
    u_light_sensor_host_model.stop();
    chk(v, exp);
  endtask
  task automatic ara();
    u_light_sensor_host_model.start();
    put({ALERT_RESPONSE_ADDR, 1'b1});
    u_light_sensor_host_model.xfer(8'hFF, 1'b1, q, ack);
    u_light_sensor_host_model.stop();
    chk(16'(q), 16'(DEV_W));
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    reset_n = 1'b0;
    sample = 32'h1234_5678;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h8A, 1, 16'h0062);
    wreg(8'h8A, 1, 16'h00FF);
    rd(8'h8A, 1, 16'h0062);
    rd(8'hAC, 2, 16'h0000);
    rd(8'hAE, 2, 16'h0000);
    chk(16'(analog_power), 16'h0000);
    wreg(8'h80, 1, 16'h0003);
    chk(16'({analog_power, integrate}), 16'h0003);
    repeat (PERIOD + 50) @(posedge clk);
    wreg(8'h8C, 1, 16'h00FF);
    rd(8'hAC, 2, 16'h1234);
    rd(8'hAE, 2, 16'h5678);
    rd(8'h8C, 1, 16'h0034);
    sample <= 32'hABCD_EF01;
    repeat (PERIOD) @(posedge clk);
    rd(8'h8D, 1, 16'h0012);
    rd(8'hAC, 2, 16'hABCD);
    wreg(8'hA2, 2, 16'h1000);
    wreg(8'hA4, 2, 16'h2000);
    sample <= 32'h1000_0000;
    wreg(8'h86, 1, 16'h0010);
    for (int i = 0; i < PERIOD + 50 && interrupt_n !== 1'b0; i++) @(posedge clk);
    chk(16'(interrupt_n), 16'h0000);
    // Clear and persistence two in one transfer, synchronised to a conversion end
    wreg(8'hC6, 1, 16'h0012);
    chk(16'(interrupt_n), 16'h0001);
    repeat (PERIOD) @(posedge clk);
    chk(16'(interrupt_n), 16'h0001);
    repeat (PERIOD) @(posedge clk);
    chk(16'(interrupt_n), 16'h0000);
    sample <= 32'h1800_0000;
    wreg(8'hC6, 1, 16'h003F);
    chk(16'(interrupt_n), 16'h0000);
    ara();
    chk(16'(interrupt_n), 16'h0001);
    // Alert style ignores the level clear; end-of-conversion fire with result in window
    wreg(8'h86, 1, 16'h0020);
    for (int i = 0; i < PERIOD + 50 && interrupt_n !== 1'b0; i++) @(posedge clk);
    wreg(8'hC0, 0, 16'h0000);
    chk(16'(interrupt_n), 16'h0000);
    ara();
    chk(16'(interrupt_n), 16'h0001);
    sample <= 32'h1000_0000;
    wreg(8'h86, 1, 16'h0000);
    repeat (PERIOD) @(posedge clk);
    chk(16'(interrupt_n), 16'h0001);
    wreg(8'h81, 1, 16'h0011);
    chk(16'(high_gain), 16'h0001);
    // Shortest period fires again well before either longer one could
    wreg(8'h81, 1, 16'h0000);
    wreg(8'h86, 1, 16'h0010);
    for (int i = 0; i < PERIOD + 50 && interrupt_n !== 1'b0; i++) @(posedge clk);
    wreg(8'hC0, 0, 16'h0000);
    repeat (1050) @(posedge clk);
    chk(16'(interrupt_n), 16'h0000);
    wreg(8'h81, 1, 16'h0003);
    chk(16'({high_gain, integrate}), 16'h0000);
    sample <= 32'h4321_8765;
    wreg(8'h81, 1, 16'h000B);
    chk(16'(integrate), 16'h0001);
    wreg(8'h81, 1, 16'h0003);
    rd(8'hAC, 2, 16'h4321);
    rd(8'hAE, 2, 16'h8765);
    print_verdict();
  end
endmodule // light_sensor_readout_and_alert_tb
